// ---- logic/tc_input_filter.sv ----
// noise filter and edge detector for timer_input_pin
// assumes the pin is synchronous to hclk; bypassed in slow mode
`timescale 1ns/1ps
module tc_input_filter
    import tc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic timer_input_pin,
    input wire logic slow_mode,
    tc_link_if.filt link
);
    logic level_ff;
    logic [3:0] run_ff;
    logic pin_ff;
    logic nxt_level;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= timer_input_pin;
        end
    end

    // a new level must hold FILT_CNT cycles: 4 rejected, 12 seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_ff <= 4'h0;
        end else if (pin_ff == level_ff || slow_mode) begin
            run_ff <= 4'h0;
        end else begin
            run_ff <= run_ff + 4'h1;
        end
    end

    always_comb begin
        nxt_level = level_ff;
        if (slow_mode) begin
            nxt_level = pin_ff;
        end else if (pin_ff != level_ff && run_ff == FILT_CNT - 4'h1) begin
            nxt_level = pin_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
        end
    end

    assign link.trig_rise = nxt_level & ~level_ff;
    assign link.trig_fall = ~nxt_level & level_ff;

    a_filter_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        !slow_mode && $changed(level_ff) |-> $past(run_ff) == FILT_CNT - 4'h1)
        else $error("filtered level changed before hold time");
endmodule : tc_input_filter

// ---- logic/tc_link_if.sv ----
// carries filtered pin edges and the prescaler tick to the core
// assumes all three ends sit on hclk
`timescale 1ns/1ps
interface tc_link_if;
    logic trig_rise;
    logic trig_fall;
    logic pre_tick;
    modport filt (output trig_rise, output trig_fall);
    modport pre (output pre_tick);
    modport core (input trig_rise, input trig_fall, input pre_tick);
endinterface : tc_link_if

// ---- logic/tc_pkg.sv ----
// constants and types of the 16-bit timer/event counter block
// assumes hclk is the fast clock of the block and runs without gaps
package tc_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMP = 8'h04;
    localparam logic [7:0] OFS_CAP = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0c;
    localparam logic [7:0] OFS_SYS = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // timer_control_register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CLK_LSB = 2;
    localparam int CTRL_START_LSB = 4;
    localparam int CTRL_OPT_BIT = 6;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // system config fields
    localparam int SYS_TAP_BIT = 0;
    localparam int SYS_SLOW_BIT = 1;
    localparam logic [1:0] SYS_RST = 2'h0;
    localparam logic [15:0] CMP_RST = 16'hffff;
    localparam logic [15:0] CAP_RST = 16'h0000;
    // start_control codes
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_SW = 2'h1;
    localparam logic [1:0] START_RISE = 2'h2;
    localparam logic [1:0] START_FALL = 2'h3;
    // operating_mode_select codes
    localparam logic [1:0] MODE_GROUP0 = 2'h0;
    localparam logic [1:0] MODE_WINDOW = 2'h1;
    localparam logic [1:0] MODE_PULSE = 2'h2;
    localparam logic [1:0] MODE_PPG = 2'h3;
    // source_clock_select codes
    localparam logic [1:0] CLK_SEL_DIV11 = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV7 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV3 = 2'h2;
    localparam logic [1:0] CLK_SEL_EXT = 2'h3;
    // divider exponents on the fast clock, and slow clock divide
    localparam int DIV_EXP_LO = 3;
    localparam int DIV_EXP_MID = 7;
    localparam int DIV_EXP_HI = 11;
    localparam int SLOW_DIV_EXP = 3;
    // input filter, in fast clock periods (hclk is the fast clock)
    localparam int FILT_REJECT_CYC = 4;
    localparam int FILT_ACCEPT_CYC = 12;
    localparam logic [3:0] FILT_CNT =
        4'((FILT_REJECT_CYC + FILT_ACCEPT_CYC) / 2);
    typedef enum logic [1:0] {
        st_idle,
        st_wait_trig,
        st_count
    } core_state_t;
endpackage : tc_pkg

// ---- logic/tc_prescaler.sv ----
// source clock tick from the fast clock divider or the slow clock
// assumes slow_clock is a level synchronous to hclk
`timescale 1ns/1ps
module tc_prescaler
    import tc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] clk_sel,
    input wire logic tap_sel,
    input wire logic slow_mode,
    input wire logic slow_clock,
    tc_link_if.pre link
);
    logic [10:0] div_ff;
    logic [2:0] slow_div_ff;
    logic slow_ff;
    logic slow_tick;
    logic fast_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 11'h000;
        end else begin
            div_ff <= div_ff + 11'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_ff <= 1'b0;
            slow_div_ff <= 3'h0;
        end else begin
            slow_ff <= slow_clock;
            if (slow_clock && !slow_ff) begin
                slow_div_ff <= slow_div_ff + 3'h1;
            end
        end
    end

    assign slow_tick = slow_clock && !slow_ff && (&slow_div_ff);

    always_comb begin
        fast_tick = 1'b0;
        unique case (clk_sel)
            CLK_SEL_DIV11: fast_tick = &div_ff[DIV_EXP_HI-1:0];
            CLK_SEL_DIV7: fast_tick = &div_ff[DIV_EXP_MID-1:0];
            CLK_SEL_DIV3: fast_tick = &div_ff[DIV_EXP_LO-1:0];
            CLK_SEL_EXT: fast_tick = 1'b0;
        endcase
    end

    // in slow mode only the 00 setting is usable, from the slow clock
    assign link.pre_tick = (clk_sel == CLK_SEL_DIV11 && (tap_sel || slow_mode))
        ? slow_tick : (slow_mode ? 1'b0 : fast_tick);

    a_div3_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_sel == CLK_SEL_DIV3 && !slow_mode && link.pre_tick
        |=> !link.pre_tick [*7])
        else $error("fast tick repeated too soon");
endmodule : tc_prescaler

// ---- logic/tc_timer_core.sv ----
// 16-bit timer / external trigger timer / event counter with capture
// assumes AHB-Lite single master; timer_input_pin synchronous to hclk
//
// Summary of operation
// - timer mode counts source ticks, clears on compare match, raises irq
// - auto-capture copies counter to capture register every source tick
// - clock select 00/01/10 divide fast clock by 2^11/2^7/2^3
// - external trigger mode starts counting on the selected pin edge
// - stop select 1: match clears, halts and raises irq
// - stop select 1: opposite edge before match clears, halts, no irq
// - halted trigger timer restarts from zero on next trigger edge
// - stop select 0: match clears, halts, irq; opposite edge no effect
// - stop select 0: trigger edge during counting is ignored
// - pin filter drops pulses up to 4 cycles, keeps 12 or more
// - slow mode bypasses filter; source holds pulses one machine cycle
// - event mode counts the selected pin edge
// - event mode checks match on opposite edge, clears, raises irq
// - start 00 stop/clear, 01 software, 10 rising, 11 falling
// - mode 00 is this group; 01, 10, 11 are other modes
// - new compare loads at first source tick after upper byte; a stopped timer loads it at once
`timescale 1ns/1ps
module tc_timer_core
    import tc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic timer_input_pin,
    input wire logic slow_clock,
    output logic match_interrupt
);
    tc_link_if link ();

    logic [7:0] ctrl_ff;
    logic [1:0] sys_ff;
    logic [15:0] cnt_ff;
    logic [15:0] cmp_ff;
    logic [15:0] cmp_buf_ff;
    logic cmp_pend_ff;
    logic [15:0] cap_ff;
    logic irq_ff;
    core_state_t state_ff;
    logic [31:0] rdata_ff;
    logic wr_ph_ff;
    logic [7:0] wr_addr_ff;
    logic [1:0] wr_lane_ff;
    logic [2:0] wr_size_ff;

    logic [1:0] mode_sel;
    logic [1:0] clk_sel;
    logic [1:0] start_ctl;
    logic opt_bit;
    logic ext_clk;
    logic edge_start;
    logic grp_ok;
    logic is_timer;
    logic is_event;
    logic is_trig;
    logic trig_edge;
    logic opp_edge;
    logic src_tick;
    logic match;
    logic addr_ok;
    logic wr_lo;
    logic wr_hi;
    logic [15:0] cnt_inc;

    assign mode_sel = ctrl_ff[CTRL_MODE_LSB +: 2];
    assign clk_sel = ctrl_ff[CTRL_CLK_LSB +: 2];
    assign start_ctl = ctrl_ff[CTRL_START_LSB +: 2];
    // one bit: auto_capture_enable or trigger_stop_select by mode
    assign opt_bit = ctrl_ff[CTRL_OPT_BIT];

    tc_input_filter u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .timer_input_pin(timer_input_pin),
        .slow_mode(sys_ff[SYS_SLOW_BIT]),
        .link(link.filt)
    );

    tc_prescaler u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_sel(clk_sel),
        .tap_sel(sys_ff[SYS_TAP_BIT]),
        .slow_mode(sys_ff[SYS_SLOW_BIT]),
        .slow_clock(slow_clock),
        .link(link.pre)
    );

    // only mode group 00 runs here; other modes leave the counter stopped
    assign grp_ok = mode_sel == MODE_GROUP0;
    assign ext_clk = clk_sel == CLK_SEL_EXT;
    assign edge_start = start_ctl == START_RISE || start_ctl == START_FALL;
    assign is_event = grp_ok && ext_clk && edge_start;
    assign is_trig = grp_ok && !ext_clk && edge_start;
    assign is_timer = grp_ok && !ext_clk && start_ctl == START_SW;
    assign trig_edge = start_ctl == START_RISE ? link.trig_rise
        : link.trig_fall;
    assign opp_edge = start_ctl == START_RISE ? link.trig_fall
        : link.trig_rise;
    assign src_tick = ext_clk ? (edge_start && trig_edge) : link.pre_tick;
    assign match = cnt_ff == cmp_ff;
    assign cnt_inc = cnt_ff + 16'h0001;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= st_idle;
            cnt_ff <= 16'h0000;
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= 1'b0;
            if (start_ctl == START_STOP || !grp_ok ||
                !(is_timer || is_event || is_trig)) begin
                state_ff <= st_idle;
                cnt_ff <= 16'h0000;
            end else begin
                unique case (state_ff)
                    st_idle: begin
                        state_ff <= is_trig ? st_wait_trig : st_count;
                    end
                    st_wait_trig: begin
                        if (!is_trig) begin
                            state_ff <= st_count;
                        end else if (trig_edge) begin
                            state_ff <= st_count;
                            cnt_ff <= 16'h0000;
                        end
                    end
                    st_count: begin
                        if (is_event) begin
                            if (opp_edge && match) begin
                                cnt_ff <= 16'h0000;
                                irq_ff <= 1'b1;
                            end else if (trig_edge) begin
                                cnt_ff <= cnt_inc;
                            end
                        end else if (is_trig) begin
                            // a re-trigger edge while counting is ignored
                            if (src_tick && match) begin
                                cnt_ff <= 16'h0000;
                                irq_ff <= 1'b1;
                                state_ff <= st_wait_trig;
                            end else if (opt_bit && opp_edge) begin
                                cnt_ff <= 16'h0000;
                                state_ff <= st_wait_trig;
                            end else if (src_tick) begin
                                cnt_ff <= cnt_inc;
                            end
                        end else if (src_tick) begin
                            if (match) begin
                                cnt_ff <= 16'h0000;
                                irq_ff <= 1'b1;
                            end else begin
                                cnt_ff <= cnt_inc;
                            end
                        end
                    end
                    default: state_ff <= st_idle;
                endcase
            end
        end
    end

    assign match_interrupt = irq_ff;

    // capture runs on the counter's own source tick, so reads may lag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_ff <= CAP_RST;
        end else if (opt_bit && (is_timer || is_event) && src_tick) begin
            cap_ff <= cnt_ff;
        end
    end

    // AHB-Lite address phase: latch writes, answer reads next cycle
    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_lane_ff <= 2'h0;
            wr_size_ff <= 3'h0;
        end else begin
            wr_ph_ff <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_ff <= {haddr[7:2], 2'h0};
                wr_lane_ff <= haddr[1:0];
                wr_size_ff <= hsize;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case ({haddr[7:2], 2'h0})
                OFS_CTRL: rdata_ff <= {24'h000000, ctrl_ff};
                OFS_CMP: rdata_ff <= {16'h0000, cmp_ff};
                OFS_CAP: rdata_ff <= {16'h0000, cap_ff};
                OFS_CNT: rdata_ff <= {16'h0000, cnt_ff};
                OFS_SYS: rdata_ff <= {30'h0, sys_ff};
                OFS_STAT: rdata_ff <= {29'h0, cmp_pend_ff,
                    state_ff == st_count, state_ff == st_wait_trig};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // byte lanes of the compare word; word or half writes cover both
    assign wr_lo = wr_size_ff != 3'h0 || wr_lane_ff == 2'h0;
    assign wr_hi = wr_size_ff != 3'h0 || wr_lane_ff == 2'h1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RST;
            sys_ff <= SYS_RST;
        end else if (wr_ph_ff) begin
            if (wr_addr_ff == OFS_CTRL && wr_lo) begin
                ctrl_ff <= hwdata[7:0];
            end
            if (wr_addr_ff == OFS_SYS && wr_lo) begin
                sys_ff <= hwdata[1:0];
            end
        end
    end

    // upper byte arms the load; a stopped timer loads at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_buf_ff <= CMP_RST;
            cmp_pend_ff <= 1'b0;
            cmp_ff <= CMP_RST;
        end else begin
            if (wr_ph_ff && wr_addr_ff == OFS_CMP) begin
                if (wr_lo) begin
                    cmp_buf_ff[7:0] <= hwdata[7:0];
                end
                if (wr_hi) begin
                    cmp_buf_ff[15:8] <= hwdata[15:8];
                    cmp_pend_ff <= 1'b1;
                end
            end else if (cmp_pend_ff &&
                (src_tick || start_ctl == START_STOP)) begin
                cmp_ff <= cmp_buf_ff;
                cmp_pend_ff <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_timer_match_clear: assert property (
        is_timer && state_ff == st_count && src_tick && match
        && $stable(ctrl_ff) |=> cnt_ff == 16'h0000 && match_interrupt)
        else $error("timer match did not clear and interrupt");
    a_capture_follows: assert property (
        opt_bit && (is_timer || is_event) && src_tick
        |=> cap_ff == $past(cnt_ff))
        else $error("capture missed the counter value");
    a_trig_wait_hold: assert property (
        is_trig && state_ff == st_wait_trig && !trig_edge && $stable(ctrl_ff)
        |=> cnt_ff == 16'h0000 && state_ff == st_wait_trig)
        else $error("trigger timer counted before its edge");
    a_trig_match_halt: assert property (
        is_trig && state_ff == st_count && src_tick && match
        && $stable(ctrl_ff) |=> state_ff == st_wait_trig && match_interrupt
        ##1 cnt_ff == 16'h0000)
        else $error("trigger match did not halt");
    a_trig_abort: assert property (
        is_trig && opt_bit && state_ff == st_count && opp_edge
        && !(src_tick && match) && $stable(ctrl_ff)
        |=> !match_interrupt && cnt_ff == 16'h0000
        && state_ff == st_wait_trig)
        else $error("opposite edge did not abort quietly");
    a_retrig_ignored: assert property (
        is_trig && !opt_bit && state_ff == st_count && !src_tick
        && $stable(ctrl_ff) |=> state_ff == st_count
        && cnt_ff == $past(cnt_ff))
        else $error("trigger timer disturbed while counting");
    a_event_count: assert property (
        is_event && state_ff == st_count && trig_edge && $stable(ctrl_ff)
        |=> cnt_ff == $past(cnt_inc))
        else $error("event edge not counted");
    a_event_match: assert property (
        is_event && state_ff == st_count && opp_edge && match
        && $stable(ctrl_ff) |=> cnt_ff == 16'h0000 && match_interrupt)
        else $error("event match not taken on opposite edge");
    a_stop_clears: assert property (
        start_ctl == START_STOP |=> cnt_ff == 16'h0000 && !match_interrupt)
        else $error("stopped counter not cleared");
    a_cmp_load: assert property (
        cmp_pend_ff && src_tick && !wr_ph_ff |=> cmp_ff == $past(cmp_buf_ff))
        else $error("compare not loaded at source tick");
endmodule : tc_timer_core

// ---- verification/tc_pulse_src.sv ----
// pulse source model on timer_input_pin
// assumes the bench calls its tasks; pin moves right after hclk edges
`timescale 1ns/1ps
module tc_pulse_src (
    input wire logic hclk,
    output logic pin
);
    initial pin = 1'b0;
    // idle level picks which edge opens a pulse
    task automatic set_idle(input logic lvl);
        @(posedge hclk);
        pin <= lvl;
    endtask : set_idle
    // levels held >= 12 cycles unless a glitch is wanted
    task automatic pulse(input int width, input int gap);
        @(posedge hclk);
        pin <= ~pin;
        repeat (width) @(posedge hclk);
        pin <= ~pin;
        repeat (gap) @(posedge hclk);
    endtask : pulse
endmodule : tc_pulse_src

// ---- verification/tc_timer_core_tb.sv ----
// self-checking bench for the timer core over AHB-Lite
// assumes tc_pulse_src drives the pin; hready loops back hreadyout
`timescale 1ns/1ps
module tc_timer_core_tb
    import tc_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, slow_clock;
    logic [31:0] haddr, hwdata, rd, seed;
    logic [1:0] htrans, sel;
    logic [2:0] hsize;
    wire logic hreadyout, hresp, match_interrupt, pin;
    wire logic [31:0] hrdata;
    int fail_count = 0, num_checks = 0, irq_cnt = 0, cyc = 0;
    int c, per, n0;

    tc_timer_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .timer_input_pin(pin),
        .slow_clock(slow_clock), .match_interrupt(match_interrupt));
    tc_pulse_src src_u (.hclk(hclk), .pin(pin));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        slow_clock <= cyc[3];
        if (match_interrupt === 1'b1)
            irq_cnt <= irq_cnt + 1;
        if (cyc == 60000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xorshift

    function automatic int div_of(input logic [1:0] s);
        case (s)
            CLK_SEL_DIV11: return 1 << DIV_EXP_HI;
            CLK_SEL_DIV7: return 1 << DIV_EXP_MID;
            default: return 1 << DIV_EXP_LO;
        endcase
    endfunction : div_of

    // one single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    // stop first so mode and clock never change while running
    task automatic cfg(input logic [7:0] ctrl, input logic [15:0] cmp);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, {24'h0, ctrl & 8'hcf});
        wr(OFS_CMP, {16'h0, cmp});
        wr(OFS_CTRL, {24'h0, ctrl});
    endtask : cfg

    task automatic wait_irq(input int lim);
        int n;
        n = irq_cnt;
        for (int i = 0; i < lim && irq_cnt == n; i++) @(posedge hclk);
    endtask : wait_irq

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        seed = 32'd53459;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(OFS_CTRL, {24'h0, CTRL_RST});
        rdc(OFS_CMP, {16'h0, CMP_RST});
        rdc(OFS_CAP, {16'h0, CAP_RST});
        rdc(OFS_CNT, 32'h0);
        rdc(8'h20, 32'h0);
        wr(OFS_SYS, 32'h0);
        rdc(OFS_SYS, 32'h0);
        $display("test reset done");
        // timer with capture, random compare, each internal divider
        for (int k = 0; k < 3; k++) begin
            seed = xorshift(seed);
            c = 1 + int'(seed % 4);
            sel = 2'(2 - k);
            per = (c + 1) * div_of(sel);
            cfg({2'b01, START_SW, sel, MODE_GROUP0}, 16'(c));
            wait_irq(per + 40);
            n0 = irq_cnt;
            repeat (2 * per) @(posedge hclk);
            chk(32'(irq_cnt - n0), 32'(2 * per / per));
            // right after a match the last capture is the compare value
            wait_irq(per + 40);
            ahb(1'b0, OFS_CAP, 32'h0);
            chk(rd, 32'(c));
            wr(OFS_CTRL, 32'h0);
            rdc(OFS_CNT, 32'h0);
            $display("test timer sel %0d done", sel);
        end
        // trigger start only: retrigger ignored, one match
        src_u.set_idle(1'b0);
        cfg({2'b00, START_RISE, CLK_SEL_DIV3, MODE_GROUP0}, 16'd20);
        repeat (100) @(posedge hclk);
        rdc(OFS_CNT, 32'h0);
        rdc(OFS_STAT, 32'h1);
        n0 = irq_cnt;
        src_u.pulse(40, 40);
        src_u.pulse(40, 120);
        chk(32'(irq_cnt - n0), 32'h1);
        rdc(OFS_CNT, 32'h0);
        $display("test trigger start done");
        // trigger start on falling edge, stop on the rising edge
        wr(OFS_CTRL, 32'h0);
        src_u.set_idle(1'b1);
        repeat (20) @(posedge hclk);
        cfg({2'b01, START_FALL, CLK_SEL_DIV3, MODE_GROUP0}, 16'd20);
        n0 = irq_cnt;
        src_u.pulse(40, 200);
        chk(32'(irq_cnt - n0), 32'h0);
        rdc(OFS_CNT, 32'h0);
        src_u.pulse(300, 40);
        chk(32'(irq_cnt - n0), 32'h1);
        $display("test trigger stop done");
        // event counter with a glitch and a boundary-width pulse
        wr(OFS_CTRL, 32'h0);
        src_u.set_idle(1'b0);
        repeat (20) @(posedge hclk);
        cfg({2'b00, START_RISE, CLK_SEL_EXT, MODE_GROUP0}, 16'd4);
        n0 = irq_cnt;
        src_u.pulse(4, 20);
        rdc(OFS_CNT, 32'h0);
        src_u.pulse(12, 16);
        src_u.pulse(16, 16);
        src_u.pulse(16, 16);
        rdc(OFS_CNT, 32'h3);
        chk(32'(irq_cnt - n0), 32'h0);
        src_u.pulse(16, 20);
        chk(32'(irq_cnt - n0), 32'h1);
        rdc(OFS_CNT, 32'h0);
        $display("test event done");
        // other mode groups keep the counter stopped
        cfg({2'b00, START_SW, CLK_SEL_DIV3, MODE_WINDOW}, 16'h1);
        n0 = irq_cnt;
        repeat (40) @(posedge hclk);
        rdc(OFS_CNT, 32'h0);
        chk(32'(irq_cnt - n0), 32'h0);
        // slow clock tap; the bench slow clock has a 16-cycle period
        wr(OFS_SYS, 32'h1);
        per = 2 * 16 * (1 << SLOW_DIV_EXP);
        cfg({2'b00, START_SW, CLK_SEL_DIV11, MODE_GROUP0}, 16'h1);
        wait_irq(per + 40);
        n0 = irq_cnt;
        repeat (2 * per) @(posedge hclk);
        chk(32'(irq_cnt - n0), 32'h2);
        // slow mode bypasses the filter, so a short pulse counts
        wr(OFS_SYS, 32'h2);
        cfg({2'b00, START_RISE, CLK_SEL_EXT, MODE_GROUP0}, 16'h2);
        src_u.pulse(3, 8);
        rdc(OFS_CNT, 32'h1);
        $display("test slow done");
        // second reset in mid-run brings the registers back
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(OFS_CTRL, {24'h0, CTRL_RST});
        rdc(OFS_CMP, {16'h0, CMP_RST});
        rdc(OFS_SYS, 32'h0);
        $display("test second reset done");
        finish_test();
    end
endmodule : tc_timer_core_tb
